// ---- spsc_pkg.sv ----
// spsc_pkg: register map, field positions and codes of the serial port
// Operation
// - enable bit activates port and takes the serial pins; clear disables it.
// - stop-in-idle set halts the port while the chip idles.
// - enhanced mode reports 3-bit count: pending as master, unread as slave.
// - enhanced mode flags an idle shifter and an empty receive fifo.
// - word ending while receive buffer unread sets overflow, word is dropped.
// - select codes 111..100 raise the event from transmit-side conditions.
// - select codes 011..000 raise the event from receive-side conditions.
// - transmit-full follows buffer writes and moves into the shifter.
// - receive-full follows shifter deliveries and software reads.
// - master clock and data-out pins can be released to general use.
// - width bit selects 16-bit words, else 8-bit bytes.
// - master samples at end of bit when phase set, else middle.
// - edge bit moves data change to active-to-idle clock edge unless framing is set.
// - slave uses active-low select only when select enable is set.
// - polarity bit idles clock high, else low.
// - master enable drives the clock; clear makes a slave.
// - secondary prescale 111 divides by one down to 000 by eight.
// - primary prescale 11,10,01,00 divide by 1,4,16,64.
// - framing runs framed transfers; direction picks sync input or output.
// - sync polarity and whether the pulse coincides with or precedes bit one.
// - enhanced enable picks fifo buffering, else single buffer.
// - enhanced mode uses eight-entry fifos, standard mode one entry.
// - master starts a transfer as soon as the buffer is written.
package spsc_pkg;
   localparam logic [3:0] A_STAT = 4'h0;
   localparam logic [3:0] A_CON1 = 4'h4;
   localparam logic [3:0] A_CON2 = 4'h8;
   localparam logic [3:0] A_BUF = 4'hC;
   localparam logic [15:0] RST_VAL = 16'h0000;
   localparam logic [15:0] C1_MASK = 16'h1FFF;
   localparam logic [15:0] C2_MASK = 16'hE003;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   localparam int S_EN = 15;
   localparam int S_SIDL = 13;
   localparam int S_ROV = 6;
   localparam int S_ISEL = 2;
   localparam int C1_CLKDIS = 12;
   localparam int C1_DODIS = 11;
   localparam int C1_WIDTH = 10;
   localparam int C1_SPH = 9;
   localparam int C1_EDGE = 8;
   localparam int C1_SSEL = 7;
   localparam int C1_POL = 6;
   localparam int C1_MST = 5;
   localparam int C1_SEC = 2;
   localparam int C1_PRI = 0;
   localparam int C2_FRM = 15;
   localparam int C2_FDIR = 14;
   localparam int C2_FPOL = 13;
   localparam int C2_FEDGE = 1;
   localparam int C2_ENH = 0;
   localparam int FIFO_DEPTH = 8;
   localparam logic [4:0] PH_LAST8 = 5'h0F;
   localparam logic [4:0] PH_LAST16 = 5'h1F;
   localparam logic [4:0] PH_SYNC = 5'h01;
   localparam logic [3:0] SEC_BASE = 4'h8;
   localparam logic [6:0] PRI_ONE = 7'h01;
   localparam logic [2:0] IS_TXFULL = 3'h7;
   localparam logic [2:0] IS_TXLAST = 3'h6;
   localparam logic [2:0] IS_DONE = 3'h5;
   localparam logic [2:0] IS_TXSLOT = 3'h4;
   localparam logic [2:0] IS_RXFULL = 3'h3;
   localparam logic [2:0] IS_RX34 = 3'h2;
   localparam logic [2:0] IS_RXAV = 3'h1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PRE = 2'b01,
      ST_SHIFT = 2'b10
   } spsc_st_t;
endpackage

// ---- spsc_top.sv ----
// spsc_top: serial port with axi4-lite registers, fifos and shifter
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module spsc_top
   import spsc_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)(
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // chip idle mode
   input wire logic IDLE_MODE,
   // axi4-lite write
   input wire logic [3:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read
   input wire logic [3:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // serial pins
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE,
   input wire logic SDI_I,
   output logic SDO_O,
   output logic SDO_OE,
   input wire logic SS_I,
   output logic SS_O,
   output logic SS_OE,
   // buffer event
   output logic IRQ_EVT
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;
   localparam logic [CW-1:0] CAP_ENH = CW'(DEPTH);
   localparam logic [CW-1:0] CAP_STD = CW'(1);
   localparam logic [CW-1:0] RX34 = CW'((DEPTH * 3) / 4);

   typedef struct packed {
      logic en;
      logic sidl;
      logic rov;
      logic [2:0] isel;
      logic [15:0] c1;
      logic [15:0] c2;
      logic [DEPTH-1:0][15:0] txm;
      logic [DEPTH-1:0][15:0] rxm;
      logic [PW-1:0] txw;
      logic [PW-1:0] txr;
      logic [PW-1:0] rxw;
      logic [PW-1:0] rxr;
      logic [CW-1:0] txc;
      logic [CW-1:0] rxc;
      spsc_st_t st;
      logic [15:0] sr;
      logic [4:0] ph;
      logic sbit;
      logic sck;
      logic prev;
      logic farm;
      logic ev;
      logic [8:0] div;
      logic aw;
      logic w;
      logic [3:0] awa;
      logic [15:0] wd;
      logic [1:0] ws;
      logic bv;
      logic rv;
      logic [1:0] br;
      logic [1:0] rr;
      logic [15:0] rd;
   } spsc_s_t;

   spsc_s_t q, n;
   logic run, mst, w16, fr, cke, sample_phase, clock_polarity, ben, sel, lead, tick, last;
   logic txpush, txpop, rxpush, rxpop, ovset, done, samp, bin, wr;
   logic txfull, rxfull, divtick;
   logic [CW-1:0] cap;
   logic [8:0] divtop;
   logic [3:0] sec;
   logic [6:0] pri;
   logic [15:0] head, shifted, wm, stat, rdv;
   logic [4:0] phlast;

   // ****************************************************************
   // configuration decode
   // ****************************************************************
   always_comb begin
      run = q.en & ~(q.sidl & IDLE_MODE);
      mst = q.c1[C1_MST];
      w16 = q.c1[C1_WIDTH];
      fr = q.c2[C2_FRM];
      cke = q.c1[C1_EDGE] & ~fr;
      sample_phase = q.c1[C1_SPH] & mst;
      clock_polarity = q.c1[C1_POL];
      ben = q.c2[C2_ENH];
      cap = ben ? CAP_ENH : CAP_STD;
      txfull = q.txc == cap;
      rxfull = q.rxc == cap;
      phlast = w16 ? PH_LAST16 : PH_LAST8;
      sec = SEC_BASE - {1'b0, q.c1[C1_SEC +: 3]};
      pri = PRI_ONE << {~q.c1[C1_PRI +: 2], 1'b0};
      divtop = 9'(pri * sec) - 9'h001;
      divtick = q.div == divtop;
      // slave select or frame arm
      sel = fr ? q.farm : (~q.c1[C1_SSEL] | ~SS_I);
      head = q.txm[q.txr];
      stat = 16'h0000;
      stat[S_EN] = q.en;
      stat[S_SIDL] = q.sidl;
      stat[10:8] = mst ? q.txc[2:0] : q.rxc[2:0];
      stat[7] = q.st == ST_IDLE;
      stat[S_ROV] = q.rov;
      stat[5] = q.rxc == '0;
      stat[S_ISEL +: 3] = q.isel;
      stat[1] = txfull;
      stat[0] = rxfull;
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      n = q;
      n.prev = SCK_I;
      txpush = 1'b0;
      txpop = 1'b0;
      rxpush = 1'b0;
      rxpop = 1'b0;
      ovset = 1'b0;
      done = 1'b0;
      samp = 1'b0;
      wr = q.aw & q.w;
      lead = ~q.ph[0];
      last = q.ph == phlast;
      tick = mst ? divtick : (q.prev != SCK_I);
      bin = q.sbit;
      shifted = q.sr;
      wm = q.wd;
      rdv = 16'h0000;
      // bus write channels, taken in either order
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
         n.aw = 1'b1;
         n.awa = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
         n.w = 1'b1;
         n.wd = S_AXI_WDATA[15:0];
         n.ws = S_AXI_WSTRB[1:0];
      end
      if (S_AXI_BVALID & S_AXI_BREADY) begin
         n.bv = 1'b0;
      end
      if (wr) begin
         n.aw = 1'b0;
         n.w = 1'b0;
         n.bv = 1'b1;
         n.br = RESP_OK;
         case (q.awa)
            A_STAT: wm = stat;
            A_CON1: wm = q.c1;
            A_CON2: wm = q.c2;
            default: wm = 16'h0000;
         endcase
         if (q.ws[0]) begin
            wm[7:0] = q.wd[7:0];
         end
         if (q.ws[1]) begin
            wm[15:8] = q.wd[15:8];
         end
         case (q.awa)
            A_STAT: begin
               n.en = wm[S_EN];
               n.sidl = wm[S_SIDL];
               n.isel = wm[S_ISEL +: 3];
               n.rov = q.rov & wm[S_ROV];
            end
            A_CON1: n.c1 = wm & C1_MASK;
            A_CON2: n.c2 = wm & C2_MASK;
            A_BUF: txpush = ~txfull & (q.ws != 2'b00);
            default: n.br = RESP_ERR;
         endcase
      end
      // bus read channel; a buffer read pops the receive side
      if (S_AXI_RVALID & S_AXI_RREADY) begin
         n.rv = 1'b0;
      end
      if (S_AXI_ARVALID & S_AXI_ARREADY) begin
         n.rv = 1'b1;
         n.rr = RESP_OK;
         case (S_AXI_ARADDR)
            A_STAT: rdv = stat;
            A_CON1: rdv = q.c1;
            A_CON2: rdv = q.c2;
            A_BUF: begin
               rdv = q.rxm[q.rxr];
               rxpop = q.rxc != '0;
            end
            default: n.rr = RESP_ERR;
         endcase
         n.rd = rdv;
      end
      // frame arm for framed slave-role transfers
      if (fr & (q.st == ST_IDLE)) begin
         n.farm = q.c2[C2_FDIR] ? (SS_I == q.c2[C2_FPOL]) : 1'b1;
      end
      // shifter
      case (q.st)
         ST_IDLE: begin
            n.ph = 5'h00;
            n.div = 9'h000;
            n.sck = clock_polarity;
            if (run & (mst ? (q.txc != '0) : sel)) begin
               txpop = q.txc != '0;
               n.sr = 16'h0000;
               if (q.txc != '0) begin
                  n.sr = w16 ? head : {head[7:0], 8'h00};
               end
               n.st = (mst & fr & ~q.c2[C2_FEDGE]) ? ST_PRE : ST_SHIFT;
            end
         end
         ST_PRE: begin
            n.div = divtick ? 9'h000 : q.div + 9'h001;
            if (~run) begin
               n.st = ST_IDLE;
            end else if (divtick) begin
               n.ph = q.ph + 5'h01;
               if (q.ph == PH_SYNC) begin
                  n.ph = 5'h00;
                  n.st = ST_SHIFT;
               end
            end
         end
         ST_SHIFT: begin
            n.div = (divtick | ~mst) ? 9'h000 : q.div + 9'h001;
            if (~run | (~mst & ~sel)) begin
               n.st = ST_IDLE;
            end else if (tick) begin
               n.sck = ~q.sck;
               n.ph = q.ph + 5'h01;
               if (cke) begin
                  samp = sample_phase ? ~lead : lead;
               end else begin
                  samp = sample_phase ? ((lead & (q.ph != 5'h00)) | last) : ~lead;
               end
               bin = samp ? SDI_I : q.sbit;
               n.sbit = bin;
               if ((cke ? ~lead : (lead & (q.ph != 5'h00))) | last) begin
                  shifted = {q.sr[14:0], bin};
                  n.sr = shifted;
               end
               if (last) begin
                  done = 1'b1;
                  n.farm = 1'b0;
                  n.st = ST_IDLE;
                  ovset = rxfull & ~rxpop;
                  rxpush = ~ovset;
               end
            end
         end
         default: n.st = ST_IDLE;
      endcase
      // fifo bookkeeping
      if (txpush) begin
         n.txm[q.txw] = q.wd;
         n.txw = q.txw + PW'(1);
      end
      if (txpop) begin
         n.txr = q.txr + PW'(1);
      end
      n.txc = q.txc + CW'(txpush) - CW'(txpop);
      if (rxpush) begin
         n.rxm[q.rxw] = w16 ? shifted : {8'h00, shifted[7:0]};
         n.rxw = q.rxw + PW'(1);
      end
      if (rxpop) begin
         n.rxr = q.rxr + PW'(1);
      end
      n.rxc = q.rxc + CW'(rxpush) - CW'(rxpop);
      if (ovset) begin
         n.rov = 1'b1;
      end
      // buffer event select
      if (~ben) begin
         n.ev = done;
      end else begin
         case (q.isel)
            IS_TXFULL: n.ev = n.txc == cap;
            IS_TXLAST: n.ev = txpop & (q.txc == CW'(1));
            IS_DONE: n.ev = done;
            IS_TXSLOT: n.ev = txpop;
            IS_RXFULL: n.ev = n.rxc == cap;
            IS_RX34: n.ev = n.rxc >= RX34;
            IS_RXAV: n.ev = n.rxc != '0;
            default: n.ev = rxpop & (q.rxc == CW'(1)) & ~rxpush;
         endcase
      end
      // disabled port drops fifo contents and any transfer
      if (~q.en) begin
         n.st = ST_IDLE;
         n.txw = '0;
         n.txr = '0;
         n.txc = '0;
         n.rxw = '0;
         n.rxr = '0;
         n.rxc = '0;
         n.farm = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         q <= '0;
         q.c1 <= RST_VAL;
         q.c2 <= RST_VAL;
         q.st <= ST_IDLE;
      end else begin
         q <= n;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign S_AXI_AWREADY = ~q.aw & ~q.bv;
   assign S_AXI_WREADY = ~q.w & ~q.bv;
   assign S_AXI_BVALID = q.bv;
   assign S_AXI_BRESP = q.br;
   assign S_AXI_ARREADY = ~q.rv;
   assign S_AXI_RVALID = q.rv;
   assign S_AXI_RRESP = q.rr;
   assign S_AXI_RDATA = {16'h0000, q.rd};
   assign SCK_O = q.sck;
   assign SCK_OE = q.en & mst & ~q.c1[C1_CLKDIS];
   assign SDO_O = q.sr[15];
   assign SDO_OE = q.en & ~q.c1[C1_DODIS];
   assign SS_O = q.c2[C2_FPOL] ~^ ((q.st == ST_PRE) |
      (q.c2[C2_FEDGE] & (q.st == ST_SHIFT) & (q.ph < 5'h02)));
   assign SS_OE = q.en & fr & ~q.c2[C2_FDIR];
   assign IRQ_EVT = q.ev;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   enable_pins_a: assert property (~q.en |-> ~SCK_OE & ~SDO_OE & ~SS_OE)
      else $error("pins driven while port disabled");
   idle_stop_a: assert property (q.en & q.sidl & IDLE_MODE &
      (q.st != ST_IDLE) |=> q.st == ST_IDLE)
      else $error("transfer kept running in idle");
   rx_ovf_a: assert property (done & rxfull & ~rxpop |=>
      q.rov & (q.rxc == $past(q.rxc)))
      else $error("overflow not flagged or word kept");
   tx_full_a: assert property (q.en & ~ben & txpush & ~txpop |=>
      S_AXI_ARREADY & txfull)
      else $error("transmit full not set after write");
   rx_empty_a: assert property (rxpop & ~rxpush & (q.rxc == CW'(1))
      |=> stat[5])
      else $error("receive empty not flagged");
   word_len_a: assert property (done |->
      (q.ph == phlast) & (q.st == ST_SHIFT))
      else $error("transfer length wrong");
   sck_rate_a: assert property (mst & (q.st == ST_SHIFT) &
      $changed(q.sck) |-> $past(divtick))
      else $error("clock toggled off the prescale tick");
   sck_idle_a: assert property ((q.st == ST_IDLE) ##1 (q.st == ST_IDLE)
      |-> q.sck == $past(clock_polarity))
      else $error("clock not at idle level");
   mst_start_a: assert property (q.en & ~(q.sidl & IDLE_MODE) & mst &
      ~fr & (q.st == ST_IDLE) & (q.txc != '0) |=> q.st == ST_SHIFT)
      else $error("master did not start on buffered data");
   wr_resp_a: assert property (wr & ~q.bv |=> S_AXI_BVALID)
      else $error("write answer missing");

   word16_c: cover property (done & w16 & mst);
   overflow_c: cover property (ovset);
   presync_c: cover property ((q.st == ST_PRE) ##[1:64] (q.st == ST_SHIFT));
endmodule // spsc_top
`default_nettype wire

// ---- spsc_far_dev.sv ----
// far-side serial slave model for the port in master role
`timescale 1ns/1ns
`default_nettype none
module spsc_far_dev (
   // serial lines
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   // word control
   input wire logic load,
   input wire logic wide,
   input wire logic [15:0] load_word,
   output logic [15:0] rx_word
);
   logic [15:0] tx_ff;
   // **********************************
   // sample on leading, shift on trailing
   // **********************************
   always @(posedge sck or posedge load) begin
      if (load) begin
         rx_word <= 16'h0000;
      end else begin
         rx_word <= {rx_word[14:0], mosi};
      end
   end
   // inverted fill so a spent line never repeats its last bit
   always @(negedge sck or posedge load) begin
      if (load) begin
         tx_ff <= load_word;
      end else begin
         tx_ff <= {tx_ff[14:0], ~tx_ff[15]};
      end
   end
   assign miso = wide ? tx_ff[15] : tx_ff[7];
endmodule // spsc_far_dev
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the serial port block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import spsc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic idle = 1'b0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic sck_o, sck_oe, sdo_o, sdo_oe, ss_o, ss_oe, irq, miso, sck_q;
   logic load = 1'b0;
   logic wide = 1'b0;
   logic [15:0] pw = 16'h0000;
   logic [15:0] prx, v;
   logic [31:0] r, q;
   int bad_count = 0;
   int check_count = 0;
   int seed = 32'hFF5B1C0C;
   int gap = 0;
   int tog = 0;
   int cnt = 0;
   int t0;

   always #5 clk = ~clk;

   spsc_top u_dut (.CLK(clk), .SYS_RST(rst), .IDLE_MODE(idle),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .SCK_I(1'b0), .SCK_O(sck_o),
      .SCK_OE(sck_oe), .SDI_I(miso), .SDO_O(sdo_o), .SDO_OE(sdo_oe),
      .SS_I(1'b1), .SS_O(ss_o), .SS_OE(ss_oe), .IRQ_EVT(irq));

   spsc_far_dev u_far (.sck(sck_oe ? sck_o : 1'b0),
      .mosi(sdo_oe ? sdo_o : ~sdo_o), .miso(miso), .load(load),
      .wide(wide), .load_word(pw), .rx_word(prx));

   // clock edge count and spacing between edges
   always @(posedge clk) begin
      sck_q <= sck_o;
      if (sck_o !== sck_q) begin
         gap <= cnt;
         cnt <= 1;
         tog <= tog + 1;
      end else begin
         cnt <= cnt + 1;
      end
   end

   // **********************************
   // shared tasks
   // **********************************
   task automatic end_sim;
      if (bad_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] e, input logic [31:0] g,
                      input string nm);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic lost;
      bad_count++;
      $display("mismatch wait expected done seen timeout");
      end_sim;
   endtask

   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [15:0] d);
      int n;
      logic at, wt, dn;
      @(posedge clk);
      if (w) begin
         awaddr <= a;
         wdata <= {16'h0000, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
      end else begin
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
      end
      dn = 1'b0;
      for (n = 0; n < 200 && !dn; n++) begin
         @(negedge clk);
         at = (awvalid && awready) || (arvalid && arready);
         wt = wvalid && wready;
         dn = (bvalid && bready) || (rvalid && rready);
         resp = w ? bresp : rresp;
         v = rdata[15:0];
         @(posedge clk);
         if (at) begin
            awvalid <= 1'b0;
            arvalid <= 1'b0;
         end
         if (wt) wvalid <= 1'b0;
         if (dn) begin
            bready <= 1'b0;
            rready <= 1'b0;
         end
      end
      if (!dn) lost;
   endtask

   task automatic rchk(input logic [3:0] a, input logic [15:0] e,
                       input string nm);
      bus(1'b0, a, 16'h0000);
      chk({16'h0000, e}, {16'h0000, v}, nm);
   endtask

   // wait for the expected clock edges, then for an idle shifter
   task automatic settle(input int edges);
      int n;
      for (n = 0; n < 20000 && tog - t0 < edges; n++) @(posedge clk);
      for (n = 0; n < 100; n++) begin
         bus(1'b0, A_STAT, 16'h0000);
         if (v[7] === 1'b1) break;
      end
      if (n == 100) lost;
   endtask

   task automatic xfer(input logic [15:0] d, input logic [15:0] p);
      @(posedge clk);
      pw <= p;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      t0 = tog;
      bus(1'b1, A_BUF, d);
      settle(wide ? 32 : 16);
   endtask

   function automatic int pmul(input logic [1:0] c);
      return c == 2'b11 ? 1 : c == 2'b10 ? 4 : c == 2'b01 ? 16 : 64;
   endfunction

   // **********************************
   // main sequence
   // **********************************
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({sck_oe, sdo_oe, ss_oe, ss_o, irq}, 5'h02, "reset pins");
      rchk(A_STAT, 16'h00A0, "stat reset");
      rchk(A_CON1, RST_VAL, "con1 reset");
      rchk(A_CON2, RST_VAL, "con2 reset");
      bus(1'b1, 4'h2, 16'hFFFF);
      chk(RESP_ERR, resp, "unmapped write");
      bus(1'b0, 4'h2, 16'h0000);
      chk(RESP_ERR, resp, "unmapped read");
      bus(1'b1, A_CON1, 16'hFFFF);
      rchk(A_CON1, C1_MASK, "con1 fields");
      bus(1'b1, A_CON2, 16'hFFFF);
      rchk(A_CON2, C2_MASK, "con2 fields");
      bus(1'b1, A_CON2, 16'h0000);
      bus(1'b1, A_CON1, 16'h0160);
      bus(1'b1, A_STAT, 16'h8000);
      chk({sck_oe, sck_o, sdo_oe, ss_oe}, 4'hE, "pins on");
      bus(1'b1, A_CON1, 16'h1960);
      chk({sck_oe, sdo_oe}, 2'b00, "pins released");
      for (int i = 0; i < 6; i++) begin
         r = $random(seed);
         q = $random(seed);
         wide <= r[5] && r[1:0] != 2'b00;
         bus(1'b1, A_CON1, {5'h00, r[5] && r[1:0] != 2'b00, 5'b01001,
                            r[4:2], r[1:0]});
         xfer(q[15:0], q[31:16]);
         chk(wide ? 32 : 16, tog - t0, "clock edges");
         chk(pmul(r[1:0]) * (8 - r[4:2]), gap, "tick period");
         chk(wide ? q[15:0] : q[7:0], prx, "sent word");
         rchk(A_BUF, wide ? q[31:16] : q[23:16], "rx word");
         rchk(A_STAT, 16'h80A0, "stat after read");
      end
      wide <= 1'b0;
      bus(1'b1, A_CON1, 16'h013B);
      xfer(16'h00A5, 16'h003C);
      xfer(16'h005A, 16'h00C3);
      rchk(A_STAT, 16'h80C1, "overflow set");
      rchk(A_BUF, 16'h003C, "kept word");
      bus(1'b1, A_STAT, 16'h8000);
      rchk(A_STAT, 16'h80A0, "overflow cleared");
      bus(1'b1, A_CON2, 16'h0001);
      bus(1'b1, A_STAT, 16'h8004);
      t0 = tog;
      for (int k = 0; k < 3; k++) bus(1'b1, A_BUF, 16'h0011 * k);
      settle(48);
      chk({v[7], v[5], v[0], irq}, 4'h9, "fifo flags");
      repeat (3) bus(1'b0, A_BUF, 16'h0000);
      bus(1'b0, A_STAT, 16'h0000);
      chk({v[10:8], v[5], irq}, 5'h02, "fifo drained");
      bus(1'b1, A_CON1, 16'h0120);
      bus(1'b1, A_STAT, 16'hA004);
      repeat (9) bus(1'b1, A_BUF, 16'h1234);
      bus(1'b0, A_STAT, 16'h0000);
      chk(v[1], 1'b1, "tx full");
      idle <= 1'b1;
      repeat (4) @(posedge clk);
      t0 = tog;
      repeat (1100) @(posedge clk);
      chk(0, tog - t0, "idle stop");
      bus(1'b1, A_STAT, 16'h0000);
      chk({sck_oe, sdo_oe}, 2'b00, "disabled pins");
      rchk(A_STAT, 16'h00A0, "flushed buffer");
      end_sim;
   end
endmodule // tb_top
`default_nettype wire
